//--- rtl/wpt_map.svh
// Purpose: register offsets, field positions and reset values of the wide timer
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes: definitions only
`ifndef WPT_MAP_SVH
`define WPT_MAP_SVH
`define WPT_OFF_WIDE_CTL 5'h00
`define WPT_OFF_SHARED_CTL 5'h04
`define WPT_OFF_RELOAD_HI 5'h08
`define WPT_OFF_RELOAD_LO 5'h0c
`define WPT_OFF_CAPT_HI 5'h10
`define WPT_OFF_CAPT_LO 5'h14
`define WPT_OFF_EDGE_STAT 5'h18
`define WPT_OFF_COUNT 5'h1c
`define WPT_CTL_EN 7
`define WPT_CTL_SINGLE 6
`define WPT_CTL_TIMEOUT 5
`define WPT_CTL_RATE_HI 4
`define WPT_CTL_RATE_LO 3
`define WPT_CTL_CAPMASK 2
`define WPT_CTL_TOMASK 1
`define WPT_CTL_PINSEL 0
`define WPT_SH_DEMOD 6
`define WPT_SH_EDGE_HI 5
`define WPT_SH_EDGE_LO 4
`define WPT_SH_OSEL_HI 3
`define WPT_SH_OSEL_LO 2
`define WPT_SH_NINIT 1
`define WPT_SH_WINIT 0
`define WPT_ST_CAP 2
`define WPT_ST_POS 1
`define WPT_ST_NEG 0
`define WPT_RST_BYTE 8'h00
`define WPT_COUNT_MAX 16'hffff
`define WPT_RESP_OKAY 2'b00
`define WPT_RESP_SLVERR 2'b10
`endif

//--- rtl/wpt_pkg.sv
// Purpose: types shared by the wide timer files
// Assumes: nothing
// Notes: output-select codes are hardware encodings
package wpt_pkg;
  typedef enum logic [1:0] {WPT_OSEL_NORMAL = 2'b00, WPT_OSEL_PINGPONG = 2'b01,
    WPT_OSEL_FORCE0 = 2'b10, WPT_OSEL_FORCE1 = 2'b11} wpt_osel_t;
  typedef enum logic [1:0] {WPT_IDLE, WPT_ARMED, WPT_RUN} wpt_state_t;
endpackage

//--- rtl/wpt_prescale.sv
// Purpose: count-rate prescaler, system clock divided by 1, 2, 4 or 8
// Assumes: run low clears the divider so every start is phase aligned
// Notes: tick is combinational from the divider flops
`timescale 1ns/1ps
module wpt_prescale
(
  input wire logic clock,
  input wire logic rst,
  input wire logic run,
  input wire logic [1:0] rate,
  output logic tick
);
  import wpt_pkg::*;
  logic [2:0] div;
  wire [2:0] mask = (3'h1 << rate) - 3'h1;

  // Free divider while running, cleared when stopped
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      div <= 3'h0;
    else if (run)
      div <= div + 3'h1;
    else
      div <= 3'h0;
  end

  assign tick = run && ((div & mask) == mask);

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_rate;
    run && $past(run) && rate == 2'h3 && $stable(rate) && tick |=> !tick [*7] ##1 (tick || !run);
  endproperty
  a_rate: assert property (p_rate) else $error("divide by 8 spacing wrong");
endmodule

//--- rtl/wpt_timer.sv
// Purpose: 16-bit down-counter for pulse transmit, edge demodulation and ping-pong
// Assumes: AXI4-Lite slave, narrow counter lives outside, inputs synchronous
// Notes: pin output lags internal level by one cycle
// Notes on behaviour
// - Unforced output while disabled shows inverse of the initial-value bit.
// - Output-select 10 or 11 forces output 0 or 1 always.
// - Enabling in transmit loads reload high*256+low and sets output to initial.
// - Terminal count in transmit toggles output, sets time-out, requests if masked in.
// - Terminal count stops in single-pass, reloads and continues in modulo-N.
// - Reload writes accepted anytime, used only at the next load.
// - Initial zero wraps to FFFF then FFFE without time-out.
// - Demodulation starts counting only at the first selected edge.
// - Later edges capture complemented count, set edge flag, reload FFFF.
// - Edge-ignore: edges ignored, narrow time-out captures without reload.
// - Writing edge-ignore 0 then 1 allows one more capture and reload.
// - Demodulation terminal count continues from FFFF and sets time-out.
// - Wide counter takes its initial output and reload at ping-pong start.
// - Ping-pong hands enable between narrow and wide counters at each terminal count while the wide counter is single-pass.
// - Output-select 00 ends ping-pong alternation.
// - Hardware clears enables at handover; time-out set on every terminal count.
// - Finishing counter requests terminal-count interrupt when its mask allows.
// - Time-out flag clears only on writing one.
// - Count-rate select divides system clock by 1, 2, 4 or 8.
`timescale 1ns/1ps
`include "wpt_map.svh"
module wpt_timer
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic signal_in,
  input wire logic narrow_terminal,
  output logic narrow_restart,
  output logic wide_counter_output,
  output logic wide_counter_output_en,
  output logic timeout_request,
  output logic capture_request
);
  import wpt_pkg::*;

  logic aw_held, w_held;
  logic [4:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  logic ctl_en, ctl_single, ctl_capmask, ctl_tomask, ctl_pinsel, flag_to;
  logic [1:0] ctl_rate, sh_edge;
  wpt_osel_t sh_osel;
  logic sh_demod, sh_ninit, sh_winit;
  logic [7:0] rl_hi, rl_lo, cap_hi, cap_lo;
  logic flag_pos, flag_neg, flag_cap, rearm, out_level, sig_prev;
  logic [15:0] count;
  wpt_state_t state;
  logic tick;

  // Write side: address and data may arrive in either order
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction
  wire wr_map = hit(aw_addr, `WPT_OFF_WIDE_CTL) || hit(aw_addr, `WPT_OFF_SHARED_CTL)
    || hit(aw_addr, `WPT_OFF_RELOAD_HI) || hit(aw_addr, `WPT_OFF_RELOAD_LO)
    || hit(aw_addr, `WPT_OFF_EDGE_STAT);
  wire wr_ok = wr_fire && w_lane0;
  wire wr_ctl = wr_ok && hit(aw_addr, `WPT_OFF_WIDE_CTL);
  wire wr_sh = wr_ok && hit(aw_addr, `WPT_OFF_SHARED_CTL);
  wire wr_st = wr_ok && hit(aw_addr, `WPT_OFF_EDGE_STAT);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 5'h00;
      w_byte <= `WPT_RST_BYTE;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WPT_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `WPT_RESP_OKAY : `WPT_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  // Read side: one-cycle answer, unmapped words read zero with SLVERR
  wire [4:0] ra = s_axi_araddr;
  wire rd_map = hit(ra, `WPT_OFF_WIDE_CTL) || hit(ra, `WPT_OFF_SHARED_CTL) || hit(ra, `WPT_OFF_RELOAD_HI)
    || hit(ra, `WPT_OFF_RELOAD_LO) || hit(ra, `WPT_OFF_CAPT_HI) || hit(ra, `WPT_OFF_CAPT_LO)
    || hit(ra, `WPT_OFF_EDGE_STAT) || hit(ra, `WPT_OFF_COUNT);
  wire [7:0] ctl_rd = {ctl_en, ctl_single, flag_to, ctl_rate, ctl_capmask, ctl_tomask, ctl_pinsel};
  wire [7:0] sh_rd = {1'b0, sh_demod, sh_edge, sh_osel, sh_ninit, sh_winit};
  wire [31:0] rd_mux = hit(ra, `WPT_OFF_WIDE_CTL) ? {24'h0, ctl_rd}
    : hit(ra, `WPT_OFF_SHARED_CTL) ? {24'h0, sh_rd}
    : hit(ra, `WPT_OFF_RELOAD_HI) ? {24'h0, rl_hi}
    : hit(ra, `WPT_OFF_RELOAD_LO) ? {24'h0, rl_lo}
    : hit(ra, `WPT_OFF_CAPT_HI) ? {24'h0, cap_hi}
    : hit(ra, `WPT_OFF_CAPT_LO) ? {24'h0, cap_lo}
    : hit(ra, `WPT_OFF_EDGE_STAT) ? {29'h0, flag_cap, flag_pos, flag_neg}
    : hit(ra, `WPT_OFF_COUNT) ? {16'h0, count} : 32'h0;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `WPT_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_map ? `WPT_RESP_OKAY : `WPT_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  assign s_axi_arready = !s_axi_rvalid;

  // Counter events; the edge detector compares against last cycle's level
  wire rise = signal_in && !sig_prev;
  wire fall = !signal_in && sig_prev;
  wire sel_edge = (sh_edge[0] && rise) || (sh_edge[1] && fall);
  wire [15:0] reload = {rl_hi, rl_lo};
  wire pp_mode = (sh_osel == WPT_OSEL_PINGPONG);
  wire en_start = wr_ctl && w_byte[`WPT_CTL_EN] && !ctl_en;
  wire pp_start = narrow_terminal && pp_mode && !sh_demod && !ctl_en;
  wire load = en_start || pp_start;
  wire running = (state == WPT_RUN);
  wire tick_hit = running && tick;
  wire at_term = tick_hit && count == 16'h0001;
  wire tx_term = at_term && !sh_demod;
  wire dm_term = at_term && sh_demod;
  wire cap_edge = running && sh_demod && sel_edge && (!ctl_single || rearm);
  wire ign_cap = running && sh_demod && ctl_single && narrow_terminal && !cap_edge;
  wire stop_hw = tx_term && ctl_single;
  wire rearm_set = wr_ctl && w_byte[`WPT_CTL_SINGLE] && !ctl_single;
  wire [15:0] next_count = load ? reload
    : cap_edge ? `WPT_COUNT_MAX
    : dm_term ? `WPT_COUNT_MAX
    : tx_term ? (ctl_single ? 16'h0000 : reload)
    : tick_hit ? count - 16'h0001 : count;

  wpt_prescale u_prescale
  (
    .clock(clock),
    .rst(rst),
    .run(running),
    .rate(ctl_rate),
    .tick(tick)
  );

  // Control registers; hardware clears the enable at single-pass end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      {ctl_en, ctl_single, ctl_rate, ctl_capmask, ctl_tomask, ctl_pinsel} <= 7'h00;
      {sh_demod, sh_edge, sh_ninit, sh_winit} <= 5'h00;
      sh_osel <= WPT_OSEL_NORMAL;
      rl_hi <= `WPT_RST_BYTE;
      rl_lo <= `WPT_RST_BYTE;
    end
    else
    begin
      if (wr_ctl)
        {ctl_single, ctl_rate, ctl_capmask, ctl_tomask, ctl_pinsel} <= {w_byte[`WPT_CTL_SINGLE], w_byte[`WPT_CTL_RATE_HI:0]};
      if (load)
        ctl_en <= 1'b1;
      else if (stop_hw || (wr_ctl && !w_byte[`WPT_CTL_EN]))
        ctl_en <= 1'b0;
      if (wr_sh)
      begin
        sh_demod <= w_byte[`WPT_SH_DEMOD];
        sh_edge <= w_byte[`WPT_SH_EDGE_HI:`WPT_SH_EDGE_LO];
        sh_osel <= wpt_osel_t'(w_byte[`WPT_SH_OSEL_HI:`WPT_SH_OSEL_LO]);
        sh_ninit <= w_byte[`WPT_SH_NINIT];
        sh_winit <= w_byte[`WPT_SH_WINIT];
      end
      if (wr_ok && hit(aw_addr, `WPT_OFF_RELOAD_HI))
        rl_hi <= w_byte;
      if (wr_ok && hit(aw_addr, `WPT_OFF_RELOAD_LO))
        rl_lo <= w_byte;
    end
  end

  // Status flags: a hardware set wins over a same-cycle write-one clear
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      {flag_to, flag_pos, flag_neg, flag_cap} <= 4'h0;
    end
    else
    begin
      flag_to <= (flag_to && !(wr_ctl && w_byte[`WPT_CTL_TIMEOUT])) || at_term;
      flag_pos <= (flag_pos && !(wr_st && w_byte[`WPT_ST_POS])) || (cap_edge && rise);
      flag_neg <= (flag_neg && !(wr_st && w_byte[`WPT_ST_NEG])) || (cap_edge && fall && !rise);
      flag_cap <= (flag_cap && !(wr_st && w_byte[`WPT_ST_CAP])) || cap_edge || ign_cap;
    end
  end

  // Sequencer and count; demodulation waits in ARMED for its first edge
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= WPT_IDLE;
      count <= 16'h0000;
      out_level <= 1'b0;
      rearm <= 1'b0;
      sig_prev <= 1'b0;
      cap_hi <= 8'h00;
      cap_lo <= 8'h00;
      narrow_restart <= 1'b0;
    end
    else
    begin
      sig_prev <= signal_in;
      count <= next_count;
      narrow_restart <= stop_hw && pp_mode;
      if (rearm_set)
        rearm <= 1'b1;
      else if (cap_edge)
        rearm <= 1'b0;
      if (cap_edge || ign_cap)
        {cap_hi, cap_lo} <= ~count;
      if (load)
        out_level <= sh_winit;
      else if (tx_term)
        out_level <= !out_level;
      if (load)
        state <= sh_demod ? WPT_ARMED : WPT_RUN;
      else if (!ctl_en || stop_hw)
        state <= WPT_IDLE;
      else if (state == WPT_ARMED && sel_edge)
        state <= WPT_RUN;
    end
  end

  // Pin and requests, all registered; force codes override the pin level in every state
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wide_counter_output <= 1'b1;
      wide_counter_output_en <= 1'b0;
      timeout_request <= 1'b0;
      capture_request <= 1'b0;
    end
    else
    begin
      if (sh_osel[1])
        wide_counter_output <= sh_osel[0];
      else
        wide_counter_output <= ctl_en ? out_level : !sh_winit;
      wide_counter_output_en <= ctl_pinsel;
      timeout_request <= flag_to && ctl_tomask;
      capture_request <= flag_cap && ctl_capmask;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_force;
    sh_osel[1] |=> wide_counter_output == $past(sh_osel[0]);
  endproperty
  a_force: assert property (p_force) else $error("forced output wrong");
  property p_idle_pin;
    !sh_osel[1] && !ctl_en |=> wide_counter_output == !$past(sh_winit);
  endproperty
  a_idle_pin: assert property (p_idle_pin) else $error("idle output wrong");
  property p_load;
    load |=> count == $past(reload) && out_level == $past(sh_winit) ##1 ctl_en;
  endproperty
  a_load: assert property (p_load) else $error("load wrong");
  property p_term_flag;
    tx_term |=> flag_to && out_level != $past(out_level) ##1 (timeout_request == ctl_tomask);
  endproperty
  a_term_flag: assert property (p_term_flag) else $error("terminal count effect missing");
  property p_single;
    tx_term && ctl_single |=> !ctl_en && state == WPT_IDLE && count == 16'h0000;
  endproperty
  a_single: assert property (p_single) else $error("single pass did not stop");
  property p_modulo;
    tx_term && !ctl_single && !load && ctl_en |=> count == $past(reload) && running;
  endproperty
  a_modulo: assert property (p_modulo) else $error("modulo reload wrong");
  property p_wrap;
    tick_hit && count == 16'h0000 && !load |=> count == 16'hffff && !$rose(flag_to);
  endproperty
  a_wrap: assert property (p_wrap) else $error("zero wrap flagged");
  property p_armed;
    state == WPT_ARMED && !sel_edge && !load && ctl_en |=> count == $past(count) && state == WPT_ARMED;
  endproperty
  a_armed: assert property (p_armed) else $error("counted before first edge");
  property p_capture;
    cap_edge && !load |=> {cap_hi, cap_lo} == ~$past(count) && count == 16'hffff && flag_cap;
  endproperty
  a_capture: assert property (p_capture) else $error("edge capture wrong");
  property p_ignore;
    ign_cap && !load && !dm_term |=> {cap_hi, cap_lo} == ~$past(count)
      && count == $past(count) - {15'h0000, $past(tick)};
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignore capture reloaded");
  property p_dm_term;
    dm_term && !load && !cap_edge && ctl_en |=> count == 16'hffff && flag_to && running;
  endproperty
  a_dm_term: assert property (p_dm_term) else $error("demod terminal wrong");
  property p_handback;
    stop_hw && pp_mode |=> narrow_restart ##1 !narrow_restart;
  endproperty
  a_handback: assert property (p_handback) else $error("ping-pong handback missing");
  c_modulo: cover property (tx_term && !ctl_single ##[1:300] tx_term);
  c_pingpong: cover property (pp_start ##[1:1000] narrow_restart);
  c_capture: cover property (cap_edge ##[1:1000] cap_edge);
endmodule

//--- bench/wpt_narrow_model.sv
// Purpose: behavioural narrow counter facing the wide timer
// Assumes: kick starts one pass, a restart pulse from the wide timer starts the next
// Notes: single-pass only, so a restart while busy is dropped like on the real counter
`timescale 1ns/1ps
module wpt_narrow_model
#(
  parameter int PASS = 6
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic kick,
  input wire logic narrow_restart,
  output logic narrow_terminal,
  output logic [7:0] passes
);
  logic [7:0] left;
  logic busy;
  // One pass per start, terminal is a one-cycle pulse
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      left <= 8'h00;
      busy <= 1'b0;
      narrow_terminal <= 1'b0;
      passes <= 8'h00;
    end
    else
    begin
      narrow_terminal <= 1'b0;
      if ((kick || narrow_restart) && !busy)
      begin
        busy <= 1'b1;
        left <= 8'(PASS);
      end
      else if (busy)
      begin
        left <= left - 8'h01;
        if (left == 8'h01)
        begin
          busy <= 1'b0;
          narrow_terminal <= 1'b1;
          passes <= passes + 8'h01;
        end
      end
    end
  end
endmodule

//--- bench/wide_pulse_timer_pingpong_test.sv
// Purpose: self-checking bench for the wide pulse timer
// Assumes: AXI4-Lite master tasks, narrow counter modelled beside the timer
// Notes: count windows allow for prescaler phase and the pin's one-cycle lag
`timescale 1ns/1ps
`include "wpt_map.svh"
module wide_pulse_timer_pingpong_test;
  import wpt_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [4:0] s_axi_awaddr = 5'h00;
  logic [4:0] s_axi_araddr = 5'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, br, r;
  logic [31:0] s_axi_rdata, v;
  logic signal_in = 1'b0, kick = 1'b0, ini, tom;
  logic narrow_terminal, narrow_restart, wide_counter_output, wide_counter_output_en;
  logic timeout_request, capture_request;
  logic [7:0] passes, p0;
  int mismatches = 0, checks_done = 0, n, t;

  // Free-running 10 MHz clock
  always #50 clock = ~clock;

  wpt_timer dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .signal_in, .narrow_terminal, .narrow_restart, .wide_counter_output,
    .wide_counter_output_en, .timeout_request, .capture_request);
  wpt_narrow_model #(.PASS(6)) narrow (.clock, .rst, .kick, .narrow_restart, .narrow_terminal, .passes);

  // Control bytes to write: {en,single,timeout}, rate, {capmask,tomask}, pin select on
  function automatic logic [7:0] cw(input logic [2:0] h, input logic [1:0] rt, input logic [1:0] m);
    return {h, rt, m, 1'b1};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    br = s_axi_bresp;
  endtask

  task automatic rd(input logic [4:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    v = s_axi_rdata;
    br = s_axi_rresp;
  endtask

  // Waits for the pin to change, bounded, leaving the cycle count in t
  task automatic tog();
    logic p;
    p = wide_counter_output;
    t = 0;
    while (wide_counter_output === p && t < 400)
    begin
      @(posedge clock);
      t++;
    end
  endtask

  task automatic pulse_in();
    signal_in <= 1'b0;
    repeat (3) @(posedge clock);
    signal_in <= 1'b1;
    repeat (4) @(posedge clock);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard, far beyond the thousand or so cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    summarize();
  end

  initial
  begin
    void'($urandom(34));
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("pin_reset", wide_counter_output, 1'b1);
    wr(`WPT_OFF_SHARED_CTL, 8'hff, 4'h0);
    chk("bresp", br, `WPT_RESP_OKAY);
    rd(`WPT_OFF_SHARED_CTL);
    chk("shared", v, 32'h0);
    chk("rresp", br, `WPT_RESP_OKAY);
    // Read-only and unaligned words answer with an error
    wr(`WPT_OFF_COUNT, 8'h00);
    chk("bresp_ro", br, `WPT_RESP_SLVERR);
    rd(5'h01);
    chk("rresp_bad", br, `WPT_RESP_SLVERR);
    chk("rd_bad", v, 32'h0);
    // Single pass at every rate, random length, level and mask
    for (int k = 0; k < 8; k++)
    begin
      r = k[1:0];
      n = $urandom_range(20, 3);
      ini = 1'($urandom_range(1, 0));
      tom = 1'($urandom_range(1, 0));
      wr(`WPT_OFF_SHARED_CTL, {7'h0, ini});
      wr(`WPT_OFF_RELOAD_HI, 8'h00);
      wr(`WPT_OFF_RELOAD_LO, n[7:0]);
      repeat (3) @(posedge clock);
      chk("pin_idle", wide_counter_output, !ini);
      wr(`WPT_OFF_WIDE_CTL, cw(3'b110, r, {1'b0, tom}));
      repeat (3) @(posedge clock);
      chk("pin_start", wide_counter_output, ini);
      chk("pin_en", wide_counter_output_en, 1'b1);
      tog();
      chk("period", t + 3 >= (n << r) && t <= (n << r) + (2 << r) + 2, 1'b1);
      repeat (3) @(posedge clock);
      chk("pin_end", wide_counter_output, !ini);
      chk("to_req", timeout_request, tom);
      rd(`WPT_OFF_WIDE_CTL);
      chk("ctl_end", v[7:5], 3'b011);
      wr(`WPT_OFF_WIDE_CTL, cw(3'b010, r, {1'b0, tom}));
      rd(`WPT_OFF_WIDE_CTL);
      chk("to_keep", v[5], 1'b1);
      wr(`WPT_OFF_WIDE_CTL, cw(3'b011, r, {1'b0, tom}));
      rd(`WPT_OFF_WIDE_CTL);
      chk("to_clear", v[5], 1'b0);
    end
    // Modulo-N with a reload change in mid-pass, then forced levels
    wr(`WPT_OFF_RELOAD_LO, 8'h05);
    wr(`WPT_OFF_WIDE_CTL, cw(3'b100, 2'b00, 2'b00));
    wr(`WPT_OFF_RELOAD_LO, 8'h09);
    tog();
    tog();
    chk("mod_period", t >= 8 && t <= 11, 1'b1);
    rd(`WPT_OFF_WIDE_CTL);
    chk("mod_run", v[7], 1'b1);
    for (int c = 2; c < 4; c++)
    begin
      wr(`WPT_OFF_SHARED_CTL, {4'h0, c[1:0], 2'b00});
      repeat (3) @(posedge clock);
      for (int i = 0; i < 12; i++)
      begin
        @(posedge clock);
        chk("forced", wide_counter_output, c[0]);
      end
    end
    wr(`WPT_OFF_WIDE_CTL, cw(3'b000, 2'b00, 2'b00));
    wr(`WPT_OFF_WIDE_CTL, cw(3'b001, 2'b00, 2'b00));
    // Zero count wraps silently
    wr(`WPT_OFF_RELOAD_LO, 8'h00);
    wr(`WPT_OFF_WIDE_CTL, cw(3'b110, 2'b00, 2'b01));
    repeat (4) @(posedge clock);
    rd(`WPT_OFF_COUNT);
    chk("wrap", v[15:0] >= 16'hffe0, 1'b1);
    rd(`WPT_OFF_WIDE_CTL);
    chk("wrap_to", v[5], 1'b0);
    wr(`WPT_OFF_WIDE_CTL, cw(3'b000, 2'b00, 2'b00));
    // Demodulation on rising edges
    wr(`WPT_OFF_RELOAD_HI, 8'hff);
    wr(`WPT_OFF_RELOAD_LO, 8'hff);
    wr(`WPT_OFF_SHARED_CTL, 8'h50);
    wr(`WPT_OFF_WIDE_CTL, cw(3'b100, 2'b00, 2'b10));
    repeat (8) @(posedge clock);
    rd(`WPT_OFF_COUNT);
    chk("armed", v[15:0], 16'hffff);
    signal_in <= 1'b1;
    repeat (10) @(posedge clock);
    signal_in <= 1'b0;
    repeat (10) @(posedge clock);
    signal_in <= 1'b1;
    repeat (4) @(posedge clock);
    rd(`WPT_OFF_CAPT_HI);
    n = v[7:0];
    rd(`WPT_OFF_CAPT_LO);
    n = n * 256 + v[7:0];
    chk("capture", n >= 17 && n <= 23, 1'b1);
    rd(`WPT_OFF_COUNT);
    chk("reloaded", v[15:0] >= 16'hffe0, 1'b1);
    rd(`WPT_OFF_EDGE_STAT);
    chk("edge_stat", v[2:0], 3'b110);
    chk("cap_req", capture_request, 1'b1);
    // Edge-ignore set after clear: one capture, then edges ignored
    wr(`WPT_OFF_EDGE_STAT, 8'h07);
    wr(`WPT_OFF_WIDE_CTL, cw(3'b110, 2'b00, 2'b10));
    pulse_in();
    rd(`WPT_OFF_EDGE_STAT);
    chk("once", v[1], 1'b1);
    wr(`WPT_OFF_EDGE_STAT, 8'h07);
    pulse_in();
    rd(`WPT_OFF_EDGE_STAT);
    chk("ignored", v[2:0], 3'b000);
    kick <= 1'b1;
    @(posedge clock);
    kick <= 1'b0;
    repeat (10) @(posedge clock);
    rd(`WPT_OFF_EDGE_STAT);
    chk("narrow_cap", v[2:0], 3'b100);
    wr(`WPT_OFF_WIDE_CTL, cw(3'b000, 2'b00, 2'b00));
    wr(`WPT_OFF_WIDE_CTL, cw(3'b011, 2'b00, 2'b01));
    wr(`WPT_OFF_EDGE_STAT, 8'h07);
    // Ping-pong alternation started from the narrow side, then ended
    wr(`WPT_OFF_RELOAD_HI, 8'h00);
    wr(`WPT_OFF_RELOAD_LO, 8'h04);
    wr(`WPT_OFF_SHARED_CTL, {4'h0, WPT_OSEL_PINGPONG, 2'b00});
    p0 = passes;
    kick <= 1'b1;
    @(posedge clock);
    kick <= 1'b0;
    repeat (60) @(posedge clock);
    chk("passes", passes - p0 >= 3, 1'b1);
    chk("pp_req", timeout_request, 1'b1);
    wr(`WPT_OFF_SHARED_CTL, 8'h00);
    repeat (20) @(posedge clock);
    p0 = passes;
    repeat (60) @(posedge clock);
    chk("stopped", passes, p0);
    summarize();
  end
endmodule
